//--- verilog/asc_regs.vh
// Notes on behaviour
// - Scan enable steps channel 0 through scan list.
// - Channel count selects one, two or four channels.
// - Buffer half status shows half being filled.
// - Interrupt after sequences per interrupt plus one.
// - Split mode alternates halves; otherwise restart at zero.
// - Alternate mode toggles Sample A and Sample B.
// - Clock source bit picks RC or system clock.
// - Auto sample time counts zero to 31 periods.
// - System clock period times divider plus one.
// - Divider ignored while RC clock selected.
// - Aux negative code 0x ties inputs to ground.
// - Aux positive bit picks inputs 0-2 or 3-5.
// - Sample A aux fields share Sample B encodings.
// - Channel 0 negative bit: input 1 or ground.
// - Channel 0 positive code map, reserved above 15.
// - Sample A channel 0 field shares that map.
// - References always supply and ground.
// - Unimplemented bits read zero, writes ignored.
// - Auto-convert trigger ends sampling by counter.
// - Results go sequentially into sixteen buffer entries.
`ifndef ASC_REGS_VH
`define ASC_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ASC_OFF_CTRL_TWO 8'h00
`define ASC_OFF_CTRL_THREE 8'h04
`define ASC_OFF_AUX_SEL 8'h08
`define ASC_OFF_MAIN_SEL 8'h0c
`define ASC_OFF_SEQ_CTRL 8'h10
`define ASC_OFF_SEQ_STAT 8'h14

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define ASC_RESET_VAL 16'h0000
`define ASC_MASK_CTRL_TWO 16'he73f
`define ASC_MASK_CTRL_THREE 16'h9fff
`define ASC_MASK_AUX_SEL 16'h0707
`define ASC_MASK_MAIN_SEL 16'h9f9f
`define ASC_MASK_SEQ_CTRL 16'h0007

// ****************************************************************
// Field positions
// ****************************************************************
`define ASC_REF_CFG_HI 15
`define ASC_REF_CFG_LO 13
`define ASC_SCAN_EN 10
`define ASC_CHCNT_HI 9
`define ASC_CHCNT_LO 8
`define ASC_BUF_HALF 7
`define ASC_SPI_HI 5
`define ASC_SPI_LO 2
`define ASC_SPLIT 1
`define ASC_ALT 0
`define ASC_CLK_SRC 15
`define ASC_SAMPT_HI 12
`define ASC_SAMPT_LO 8
`define ASC_DIV_HI 7
`define ASC_DIV_LO 0
`define ASC_AUX_NEG_B_HI 10
`define ASC_AUX_NEG_B_LO 9
`define ASC_AUX_POS_B 8
`define ASC_AUX_NEG_A_HI 2
`define ASC_AUX_NEG_A_LO 1
`define ASC_AUX_POS_A 0
`define ASC_MAIN_NEG_B 15
`define ASC_MAIN_POS_B_HI 12
`define ASC_MAIN_POS_B_LO 8
`define ASC_MAIN_NEG_A 7
`define ASC_MAIN_POS_A_HI 4
`define ASC_MAIN_POS_A_LO 0
`define ASC_TRIG_HI 2
`define ASC_TRIG_LO 0

// ****************************************************************
// Encodings
// ****************************************************************
`define ASC_TRIG_AUTO 3'h7
`define ASC_DIV_RESERVED 8'h40
`define ASC_POS_LAST_PIN 5'h0c
`define ASC_POS_TEMP 5'h0d
`define ASC_POS_FLOAT 5'h0e
`define ASC_POS_PIN15 5'h0f
`define ASC_SPLIT_BASE 4'h8

`endif

//--- verilog/asc_tad_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.vh"

// ****************************************************************
// Conversion clock period tick generator
// ****************************************************************
module asc_tad_gen (
  input wire clock,
  input wire sys_rst,
  input wire rcClock,
  input wire useRc,
  input wire [7:0] divider,
  output reg tadTick
);

  reg rcSync1_q;
  reg rcSync2_q;
  reg rcLast_q;
  reg [7:0] divCount_q;
  wire divReserved;

  assign divReserved = (divider >= `ASC_DIV_RESERVED);

  // The RC clock is foreign, so it is synchronised before its edge is used.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rcSync1_q <= 1'b0;
      rcSync2_q <= 1'b0;
      rcLast_q <= 1'b0;
    end else begin
      rcSync1_q <= rcClock;
      rcSync2_q <= rcSync1_q;
      rcLast_q <= rcSync2_q;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      divCount_q <= 8'h00;
      tadTick <= 1'b0;
    end else if (useRc) begin
      divCount_q <= 8'h00;
      tadTick <= rcSync2_q & ~rcLast_q;
    end else if (divReserved) begin
      // A reserved divider stops the clock rather than guessing a rate.
      divCount_q <= 8'h00;
      tadTick <= 1'b0;
    end else if (divCount_q >= divider) begin
      divCount_q <= 8'h00;
      tadTick <= 1'b1;
    end else begin
      divCount_q <= divCount_q + 8'h01;
      tadTick <= 1'b0;
    end
  end

endmodule // asc_tad_gen

`default_nettype wire

//--- verilog/asc_seq_control.v
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.vh"

// ****************************************************************
// Sequence, buffer and input selection control
// ****************************************************************
module asc_seq_control #(
  parameter [1:0] PART_CLASS = 2'd2,
  parameter [15:0] PIN_AVAIL = 16'h9fff
) (
  input wire clock,
  input wire sys_rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire rcClock,
  input wire [15:0] scanList,
  input wire sampleStart,
  input wire convDone,
  output wire tadTick,
  output reg sampleEnd,
  output reg convIrq,
  output reg bufWrite,
  output reg [3:0] bufAddr,
  output reg [3:0] activeChannels,
  output reg samplePhaseB,
  output reg [4:0] mainPosSel,
  output reg mainPosConnect,
  output reg mainTempSense,
  output reg mainNegPin1,
  output reg auxPosHigh,
  output reg [2:0] auxPosConnect,
  output reg [1:0] auxNegSel,
  output reg [2:0] auxNegConnect,
  output reg auxNegGround,
  output reg refUpperSupply,
  output reg refLowerGround
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [15:0] ctrlTwo_q;
  reg [15:0] ctrlThree_q;
  reg [15:0] auxSel_q;
  reg [15:0] mainSel_q;
  reg [15:0] seqCtrl_q;
  reg bufHalf_q;
  reg [3:0] bufPtr_q;
  reg [1:0] convIdx_q;
  reg [3:0] seqCount_q;
  reg phaseB_q;
  reg [3:0] scanPtr_q;
  reg sampling_q;
  reg [4:0] sampleLeft_q;

  wire setupPhase;
  wire writeAccess;
  wire [15:0] byteMask;
  wire [15:0] readCtrlTwo;
  wire [15:0] statusWord;
  wire scanOn;
  wire splitOn;
  wire altOn;
  wire [1:0] chanCount;
  wire [3:0] seqLimit;
  wire [2:0] trigSel;
  wire [4:0] sampleTime;
  wire seqDone;
  wire irqNow;
  wire [3:0] scanFirst;
  wire [3:0] scanNext;
  reg [1:0] lastIdx;
  reg [15:0] readWord;
  reg mapped;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [15:0] merge_word;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [15:0] strobes;
    input [15:0] writable;
    begin
      merge_word = (oldVal & ~(strobes & writable)) |
        (newVal & strobes & writable);
    end
  endfunction

  // Finds the next selected input after cur, wrapping round the list.
  function [3:0] scan_step;
    input [3:0] cur;
    input [15:0] lst;
    integer i;
    reg hit;
    reg [3:0] idx;
    begin
      hit = 1'b0;
      scan_step = cur;
      for (i = 1; i <= 16; i = i + 1) begin
        idx = cur + i[3:0];
        if (!hit && lst[idx]) begin
          hit = 1'b1;
          scan_step = idx;
        end
      end
    end
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign setupPhase = psel & ~penable;
  assign writeAccess = psel & penable & pwrite;
  assign pready = 1'b1;
  assign byteMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // The half bit is state, not storage, so it is merged in on read.
  assign readCtrlTwo = (ctrlTwo_q & `ASC_MASK_CTRL_TWO) |
    {8'h00, splitOn & bufHalf_q, 7'h00};
  assign statusWord = {2'b00, sampling_q, phaseB_q, scanPtr_q,
    seqCount_q, bufPtr_q};

  always @* begin
    mapped = 1'b1;
    case (paddr)
      `ASC_OFF_CTRL_TWO: begin
        readWord = readCtrlTwo;
      end
      `ASC_OFF_CTRL_THREE: begin
        readWord = ctrlThree_q & `ASC_MASK_CTRL_THREE;
      end
      `ASC_OFF_AUX_SEL: begin
        readWord = auxSel_q & `ASC_MASK_AUX_SEL;
      end
      `ASC_OFF_MAIN_SEL: begin
        readWord = mainSel_q & `ASC_MASK_MAIN_SEL;
      end
      `ASC_OFF_SEQ_CTRL: begin
        readWord = seqCtrl_q & `ASC_MASK_SEQ_CTRL;
      end
      `ASC_OFF_SEQ_STAT: begin
        readWord = statusWord;
      end
      default: begin
        readWord = 16'h0000;
        mapped = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup cycle so that it leaves a flop.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= {16'h0000, readWord};
      pslverr <= ~mapped;
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlTwo_q <= `ASC_RESET_VAL;
      ctrlThree_q <= `ASC_RESET_VAL;
      auxSel_q <= `ASC_RESET_VAL;
      mainSel_q <= `ASC_RESET_VAL;
      seqCtrl_q <= `ASC_RESET_VAL;
    end else if (writeAccess) begin
      case (paddr)
        `ASC_OFF_CTRL_TWO: begin
          ctrlTwo_q <= merge_word(ctrlTwo_q, pwdata[15:0], byteMask,
            `ASC_MASK_CTRL_TWO);
        end
        `ASC_OFF_CTRL_THREE: begin
          ctrlThree_q <= merge_word(ctrlThree_q, pwdata[15:0], byteMask,
            `ASC_MASK_CTRL_THREE);
        end
        `ASC_OFF_AUX_SEL: begin
          auxSel_q <= merge_word(auxSel_q, pwdata[15:0], byteMask,
            `ASC_MASK_AUX_SEL);
        end
        `ASC_OFF_MAIN_SEL: begin
          mainSel_q <= merge_word(mainSel_q, pwdata[15:0], byteMask,
            `ASC_MASK_MAIN_SEL);
        end
        `ASC_OFF_SEQ_CTRL: begin
          seqCtrl_q <= merge_word(seqCtrl_q, pwdata[15:0], byteMask,
            `ASC_MASK_SEQ_CTRL);
        end
        default: begin
          seqCtrl_q <= seqCtrl_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  assign scanOn = ctrlTwo_q[`ASC_SCAN_EN];
  assign splitOn = ctrlTwo_q[`ASC_SPLIT];
  assign altOn = ctrlTwo_q[`ASC_ALT];
  assign chanCount = ctrlTwo_q[`ASC_CHCNT_HI:`ASC_CHCNT_LO];
  assign seqLimit = ctrlTwo_q[`ASC_SPI_HI:`ASC_SPI_LO];
  assign trigSel = seqCtrl_q[`ASC_TRIG_HI:`ASC_TRIG_LO];
  assign sampleTime = ctrlThree_q[`ASC_SAMPT_HI:`ASC_SAMPT_LO];

  always @* begin
    if (chanCount[1]) begin
      lastIdx = 2'd3;
    end else if (chanCount[0]) begin
      lastIdx = 2'd1;
    end else begin
      lastIdx = 2'd0;
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  asc_tad_gen u_tad (
    .clock(clock),
    .sys_rst(sys_rst),
    .rcClock(rcClock),
    .useRc(ctrlThree_q[`ASC_CLK_SRC]),
    .divider(ctrlThree_q[`ASC_DIV_HI:`ASC_DIV_LO]),
    .tadTick(tadTick)
  );

  // ****************************************************************
  // Auto-sample timer
  // ****************************************************************
  // Other trigger sources end sampling elsewhere; the counter then idles.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sampling_q <= 1'b0;
      sampleLeft_q <= 5'h00;
      sampleEnd <= 1'b0;
    end else if (sampleStart && trigSel == `ASC_TRIG_AUTO) begin
      sampling_q <= 1'b1;
      sampleLeft_q <= sampleTime;
      sampleEnd <= 1'b0;
    end else if (sampling_q && sampleLeft_q == 5'h00) begin
      sampling_q <= 1'b0;
      sampleEnd <= 1'b1;
    end else begin
      sampleEnd <= 1'b0;
      if (sampling_q && tadTick) begin
        sampleLeft_q <= sampleLeft_q - 5'h01;
      end
    end
  end

  // ****************************************************************
  // Sequence and buffer control
  // ****************************************************************
  assign seqDone = convDone && (convIdx_q == lastIdx);
  assign irqNow = seqDone && (seqCount_q == seqLimit);
  assign scanFirst = scan_step(4'hf, scanList);
  assign scanNext = scan_step(scanPtr_q, scanList);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      convIdx_q <= 2'd0;
      seqCount_q <= 4'h0;
      convIrq <= 1'b0;
      bufWrite <= 1'b0;
      bufAddr <= 4'h0;
      bufPtr_q <= 4'h0;
      bufHalf_q <= 1'b0;
    end else begin
      bufWrite <= convDone;
      convIrq <= irqNow;
      if (convDone) begin
        bufAddr <= bufPtr_q;
        convIdx_q <= seqDone ? 2'd0 : convIdx_q + 2'd1;
      end
      if (irqNow) begin
        seqCount_q <= 4'h0;
        if (splitOn) begin
          bufHalf_q <= ~bufHalf_q;
          bufPtr_q <= bufHalf_q ? 4'h0 : `ASC_SPLIT_BASE;
        end else begin
          bufHalf_q <= 1'b0;
          bufPtr_q <= 4'h0;
        end
      end else begin
        if (seqDone) begin
          seqCount_q <= seqCount_q + 4'h1;
        end
        if (convDone) begin
          bufPtr_q <= bufPtr_q + 4'h1;
        end
        if (!splitOn) begin
          bufHalf_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Sample A and B alternation and input scan
  // ****************************************************************
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phaseB_q <= 1'b0;
      scanPtr_q <= 4'h0;
    end else begin
      if (!altOn) begin
        phaseB_q <= 1'b0;
      end else if (seqDone) begin
        phaseB_q <= ~phaseB_q;
      end
      // The list restarts at each interrupt so every batch starts alike.
      if (!scanOn || irqNow) begin
        scanPtr_q <= scanFirst;
      end else if (seqDone && !phaseB_q) begin
        scanPtr_q <= scanNext;
      end
    end
  end

  // ****************************************************************
  // Input multiplexer selection
  // ****************************************************************
  reg [4:0] posCode;
  reg posBit;
  reg [1:0] negCode;

  always @* begin
    if (phaseB_q) begin
      posCode = mainSel_q[`ASC_MAIN_POS_B_HI:`ASC_MAIN_POS_B_LO];
      posBit = auxSel_q[`ASC_AUX_POS_B];
      negCode = auxSel_q[`ASC_AUX_NEG_B_HI:`ASC_AUX_NEG_B_LO];
    end else begin
      posCode = scanOn ? {1'b0, scanPtr_q} :
        mainSel_q[`ASC_MAIN_POS_A_HI:`ASC_MAIN_POS_A_LO];
      posBit = auxSel_q[`ASC_AUX_POS_A];
      negCode = auxSel_q[`ASC_AUX_NEG_A_HI:`ASC_AUX_NEG_A_LO];
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      activeChannels <= 4'h0;
      samplePhaseB <= 1'b0;
      mainPosSel <= 5'h00;
      mainPosConnect <= 1'b0;
      mainTempSense <= 1'b0;
      mainNegPin1 <= 1'b0;
      auxPosHigh <= 1'b0;
      auxPosConnect <= 3'h0;
      auxNegSel <= 2'h0;
      auxNegConnect <= 3'h0;
      auxNegGround <= 1'b0;
      refUpperSupply <= 1'b0;
      refLowerGround <= 1'b0;
    end else begin
      activeChannels <= {lastIdx[1], lastIdx[1], |lastIdx, 1'b1};
      samplePhaseB <= phaseB_q;
      refUpperSupply <= 1'b1;
      refLowerGround <= 1'b1;
      mainPosSel <= posCode;
      mainPosConnect <= (posCode <= `ASC_POS_LAST_PIN ||
        posCode == `ASC_POS_PIN15) && PIN_AVAIL[posCode[3:0]];
      mainTempSense <= (posCode == `ASC_POS_TEMP);
      mainNegPin1 <= phaseB_q ? mainSel_q[`ASC_MAIN_NEG_B] :
        mainSel_q[`ASC_MAIN_NEG_A];
      auxPosHigh <= posBit;
      auxPosConnect <= (posBit && PART_CLASS == 2'd0) ? 3'b001 : 3'b111;
      auxNegSel <= negCode;
      auxNegGround <= ~negCode[1];
      case (negCode)
        2'b11: begin
          auxNegConnect <= (PART_CLASS == 2'd2) ? 3'b111 :
            (PART_CLASS == 2'd1) ? 3'b011 : 3'b000;
        end
        2'b10: begin
          auxNegConnect <= (PART_CLASS == 2'd2) ? 3'b111 : 3'b000;
        end
        default: begin
          auxNegConnect <= 3'b000;
        end
      endcase
    end
  end

endmodule // asc_seq_control

`default_nettype wire

//--- dv/asc_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Port checker
// ********************
module asc_seq_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic convDone,
  input wire logic bufWrite,
  input wire logic convIrq,
  input wire logic [3:0] bufAddr,
  input wire logic [4:0] mainPosSel,
  input wire logic mainPosConnect,
  input wire logic mainTempSense,
  input wire logic [1:0] auxNegSel,
  input wire logic auxNegGround,
  input wire logic [2:0] auxNegConnect,
  input wire logic refUpperSupply,
  input wire logic refLowerGround
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // The last write is kept so that buffer order is checked across gaps.
  logic seenWrite_q;
  logic lastIrq_q;
  logic [3:0] lastAddr_q;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seenWrite_q <= 1'b0;
      lastIrq_q <= 1'b0;
      lastAddr_q <= 4'h0;
    end else if (bufWrite) begin
      seenWrite_q <= 1'b1;
      lastIrq_q <= convIrq;
      lastAddr_q <= bufAddr;
    end
  end
  a_write_follows: assert property (convDone |=> bufWrite)
    else $error("no buffer write after conversion");
  a_write_cause: assert property (bufWrite |-> $past(convDone))
    else $error("buffer write without conversion");
  a_irq_on_write: assert property (convIrq |-> bufWrite)
    else $error("interrupt apart from last write");
  a_addr_step: assert property (bufWrite && seenWrite_q && !lastIrq_q
    |-> bufAddr == lastAddr_q + 4'h1)
    else $error("buffer index not sequential");
  a_half_start: assert property (bufWrite && lastIrq_q
    |-> bufAddr[2:0] == 3'h0)
    else $error("fill does not restart at a half");
  a_ref_fixed: assert property (!$past(sys_rst)
    |-> refUpperSupply && refLowerGround)
    else $error("reference selection wrong");
  a_neg_ground: assert property (!$past(sys_rst)
    |-> auxNegGround == !auxNegSel[1])
    else $error("aux negative ground wrong");
  a_neg_open: assert property (auxNegGround |-> auxNegConnect == 3'h0)
    else $error("aux negative pins while grounded");
  a_temp_code: assert property (!$past(sys_rst)
    |-> mainTempSense == (mainPosSel == 5'h0d))
    else $error("temperature select wrong");
  a_reserved_open: assert property (mainTempSense || mainPosSel[4]
    || mainPosSel == 5'h0e |-> !mainPosConnect)
    else $error("pin connected for non-pin code");
endmodule // asc_seq_asserts

bind asc_seq_control asc_seq_asserts asc_seq_asserts_i (
  .clock, .sys_rst, .convDone, .bufWrite, .convIrq, .bufAddr,
  .mainPosSel, .mainPosConnect, .mainTempSense, .auxNegSel,
  .auxNegGround, .auxNegConnect, .refUpperSupply, .refLowerGround
);
`default_nettype wire

//--- dv/asc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Converter stand-in
// ********************
module asc_conv_model (
  input wire logic clock,
  input wire logic go,
  input wire logic slow,
  input wire logic [3:0] activeChannels,
  output logic sampleStart = 1'b0,
  output logic convDone = 1'b0,
  output logic busy = 1'b0
);
  int n;
  // Slow mode spaces the results so gaps in the fill order get exercised.
  always begin
    @(posedge clock);
    if (go === 1'b1) begin
      n = $countones(activeChannels);
      busy <= 1'b1;
      sampleStart <= 1'b1;
      @(posedge clock);
      sampleStart <= 1'b0;
      repeat (slow ? 40 : 1) @(posedge clock);
      repeat (n) begin
        convDone <= 1'b1;
        @(posedge clock);
        if (slow) begin
          convDone <= 1'b0;
          @(posedge clock);
        end
      end
      convDone <= 1'b0;
      busy <= 1'b0;
    end
  end
endmodule // asc_conv_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.vh"
// ********************
// Self-checking bench
// ********************
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic rcClock = 1'b0;
  logic [15:0] scanList = 16'h0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic [2:0] rcCnt = 3'h0;
  wire [31:0] prdata;
  wire pready, pslverr, sampleStart, convDone, tadTick, sampleEnd, convIrq;
  wire bufWrite, samplePhaseB, mainPosConnect, mainTempSense, mainNegPin1;
  wire auxPosHigh, auxNegGround, refUpperSupply, refLowerGround, busy;
  wire [3:0] bufAddr, activeChannels;
  wire [4:0] mainPosSel;
  wire [2:0] auxPosConnect, auxNegConnect;
  wire [1:0] auxNegSel;
  wire [7:0] mainView = {mainNegPin1, mainTempSense, mainPosConnect,
    mainPosSel};
  wire [11:0] auxView = {auxPosConnect, auxNegConnect, auxNegGround,
    auxNegSel, auxPosHigh, refUpperSupply, refLowerGround};
  logic [15:0] wMask [5] = '{`ASC_MASK_CTRL_TWO, `ASC_MASK_CTRL_THREE,
    `ASC_MASK_AUX_SEL, `ASC_MASK_MAIN_SEL, `ASC_MASK_SEQ_CTRL};
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tStart = 0;
  int tEnd = 0;
  logic [4:0] wq [$];

  asc_seq_control asc_seq_control_i (.clock, .sys_rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .rcClock, .scanList, .sampleStart, .convDone, .tadTick, .sampleEnd,
    .convIrq, .bufWrite, .bufAddr, .activeChannels, .samplePhaseB,
    .mainPosSel, .mainPosConnect, .mainTempSense, .mainNegPin1,
    .auxPosHigh, .auxPosConnect, .auxNegSel, .auxNegConnect,
    .auxNegGround, .refUpperSupply, .refLowerGround);
  asc_conv_model asc_conv_model_i (.clock, .go, .slow, .activeChannels,
    .sampleStart, .convDone, .busy);

  always #2.5 clock = ~clock;

  // The RC clock runs free at one eighth of the system clock.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rcCnt <= rcCnt + 3'h1;
    rcClock <= rcCnt[2];
    if (!sys_rst && bufWrite === 1'b1) wq.push_back({convIrq, bufAddr});
    if (sampleStart === 1'b1) tStart <= cyc;
    if (sampleEnd === 1'b1) tEnd <= cyc;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int k;
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(a, 1'b1, d, rd, er);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(a, 1'b0, 32'h0, rd, er);
    chk(rd, exp);
  endtask

  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    wq.delete();
  endtask

  // Early ticks after a divider change are skipped as they may be short.
  task automatic tickGap(output int g);
    repeat (4) begin
      g = 0;
      do begin
        @(posedge clock);
        g++;
      end while (tadTick !== 1'b1 && g < 300);
    end
  endtask

  task automatic runSeq();
    int m;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    m = 0;
    do begin
      @(posedge clock);
      m++;
    end while (busy !== 1'b0 && m < 900);
    if (m == 900) n_fail++;
    repeat (3) @(posedge clock);
  endtask

  function automatic logic [31:0] expWrite(input int k, input int per,
      input int sp);
    int off;
    off = k % per + (((k / per) % 2 == 1 && sp == 1) ? 8 : 0);
    return {27'h0, k % per == per - 1, off[3:0]};
  endfunction

  // Input picked by the scan after n sequences since the list restarted.
  function automatic logic [31:0] scanPick(input logic [15:0] l,
      input int n);
    int c;
    c = 0;
    scanPick = 32'h0;
    n = n % $countones(l);
    for (int b = 0; b < 16; b++) begin
      if (l[b]) begin
        if (c == n) scanPick = 32'(b);
        c++;
      end
    end
  endfunction

  initial begin
    int i, k, j, spi, cc, per, sp, alt, cA, cB, m, g, t;
    logic [31:0] d;
    logic [31:0] x;
    logic [31:0] r;
    logic e;
    d = $urandom(27);
    doReset();
    for (i = 0; i < 5; i++) rdc(8'(i * 4), 32'h0);
    repeat (3) begin
      for (i = 0; i < 5; i++) begin
        d = $urandom;
        wr(8'(i * 4), d);
        rdc(8'(i * 4), {16'h0, d[15:0] & wMask[i]});
      end
    end
    apb(8'h20, 1'b1, 32'hffff, r, e);
    chk(32'(e), 32'h1);
    apb(8'h20, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    doReset();
    for (i = 0; i < 32; i++) begin
      d = $urandom;
      wr(8'h0c, {16'h0, d[15], 2'h0, d[12:8], d[7], 2'h0, i[4:0]});
      repeat (2) @(posedge clock);
      x = {24'h0, d[7], i == 13, i <= 12 || i == 15, i[4:0]};
      chk(32'(mainView), x);
    end
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      wr(8'h08, {21'h0, d[2:0], 5'h0, i[2:0]});
      repeat (2) @(posedge clock);
      x = {20'h0, 3'h7, i[2] ? 3'h7 : 3'h0, !i[2], i[2:1], i[0], 2'h3};
      chk(32'(auxView), x);
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h00, {22'h0, i[1:0], 8'h0});
      repeat (2) @(posedge clock);
      chk(32'(activeChannels), i == 0 ? 32'h1 : i == 1 ? 32'h3 : 32'hf);
    end
    for (j = 0; j < 6; j++) begin
      doReset();
      spi = j == 5 ? 15 : $urandom_range(3);
      cc = j == 5 ? 0 : $urandom_range(3);
      per = (spi + 1) * (cc == 0 ? 1 : cc == 1 ? 2 : 4);
      sp = per <= 8 ? $urandom_range(1) : 0;
      alt = $urandom_range(1);
      slow <= 1'($urandom_range(1));
      cA = $urandom_range(12);
      cB = $urandom_range(12);
      wr(8'h0c, {16'h0, 1'b1, 2'h0, cB[4:0], 3'h0, cA[4:0]});
      wr(8'h00, {22'h0, cc[1:0], 2'h0, spi[3:0], sp[0], alt[0]});
      repeat (2) @(posedge clock);
      for (k = 0; k < 2 * (spi + 1); k++) begin
        if (k == spi + 1) begin
          apb(8'h00, 1'b0, 32'h0, r, e);
          chk(32'(r[7]), 32'(sp));
        end
        x = (alt == 1 && k[0]) ? cB : cA;
        chk({samplePhaseB, mainPosSel}, {alt[0] & k[0], x[4:0]});
        chk(32'(mainNegPin1), 32'(alt[0] & k[0]));
        runSeq();
      end
      chk(wq.size(), 2 * per);
      for (k = 0; k < 2 * per; k++) chk(32'(wq[k]), expWrite(k, per, sp));
    end
    doReset();
    scanList <= 16'($urandom) | 16'h8000;
    wr(8'h00, 32'h0000040c);
    repeat (2) @(posedge clock);
    for (k = 0; k < 8; k++) begin
      chk(32'(mainPosSel), scanPick(scanList, k % 4));
      runSeq();
    end
    doReset();
    for (i = 0; i < 4; i++) begin
      d = i == 0 ? 0 : i == 1 ? 63 : $urandom_range(62, 1);
      wr(8'h04, {24'h0, d[7:0]});
      tickGap(g);
      chk(g, d + 1);
    end
    wr(8'h04, {16'h0, 1'b1, 7'h0, 8'($urandom)});
    tickGap(g);
    chk(g, 32'h8);
    wr(8'h04, 32'h40);
    repeat (20) @(posedge clock);
    m = 0;
    repeat (300) begin
      @(posedge clock);
      if (tadTick === 1'b1) m++;
    end
    chk(m, 0);
    slow <= 1'b1;
    for (i = 0; i < 3; i++) begin
      t = i == 0 ? 0 : i == 1 ? 31 : $urandom_range(30, 1);
      wr(8'h04, {19'h0, t[4:0], 8'h0});
      wr(8'h10, 32'h7);
      tEnd = 0;
      runSeq();
      m = tEnd - tStart;
      chk(32'(m >= t + 1 && m <= t + 4), 32'h1);
    end
    wr(8'h10, 32'h0);
    tEnd = 0;
    runSeq();
    chk(tEnd, 0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
